/* File: hw/gpio_pkg.sv */
// package: register map, reset values and carriers for the gpio block
package gpio_pkg;
  localparam int NPIN = 19;
  localparam int NIRQ = 16;
  localparam int AW = 8;
  // ************************************************
  // register offsets (byte addresses)
  // ************************************************
  localparam logic [7:0] A_IN = 8'h00;
  localparam logic [7:0] A_OUT = 8'h04;
  localparam logic [7:0] A_DIR = 8'h08;
  localparam logic [7:0] A_PEN = 8'h0C;
  localparam logic [7:0] A_PSEL = 8'h10;
  localparam logic [7:0] A_EDGE = 8'h14;
  localparam logic [7:0] A_IE = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  localparam logic [7:0] A_CLR = 8'h20;
  localparam logic [7:0] A_LOCK = 8'h24;
  // ************************************************
  // field masks and reset values
  // ************************************************
  localparam logic [31:0] PIN_MASK = 32'h0007FFFF;
  localparam logic [31:0] IRQ_MASK = 32'h0000FFFF;
  localparam int LOCK_BIT = 0;
  localparam logic RST_LOCK = 1'b1;
  localparam logic [18:0] RST_PINS = 19'h00000;
  localparam logic [15:0] RST_IRQ = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic [18:0] out;
    logic [18:0] oe;
    logic [18:0] pull_en;
    logic [18:0] pull_up;
    logic [18:0] in_en;
  } pad_t;
  typedef struct packed {
    logic [18:0] out;
    logic [18:0] dir;
    logic [18:0] pen;
    logic [18:0] psel;
    logic [15:0] edge_sel;
    logic [15:0] ie;
  } cfg_t;
endpackage

/* File: hw/gpio_ports.sv */
// gpio ports: two 8-bit groups and one 3-bit group behind an axi4-lite slave
//
// Behaviour
// - two 8-bit port groups plus a third group of three bits
// - every pin configured on its own, no shared settings
// - any mix of input, output and interrupt per bit of groups one and two
// - per-pin pull resistor, selectable up or down
// - groups one and two raise edge interrupts; group three none
// - group one and two events wake the device from deep sleep
// - registers take reads, writes and read-modify-write sequences
// - registers reached bytewise or as a 16-bit pair of groups
// - after reset pins high-impedance, input trigger off, no cross current
// - software configures first, then clears lock; i/o stays off until then
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module gpio_ports
  import gpio_pkg::*;
#(
  parameter int G3_BITS = 3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic [NPIN-1:0] pin_in,
  output pad_t pads,
  // system
  input wire logic deep_sleep,
  output logic irq,
  output logic wake_req
);
  // ************************************************
  // elaboration checks
  // ************************************************
  if (G3_BITS != NPIN - 16) begin : g_bad
    $error("G3_BITS must match the pin count");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r & m;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return a <= A_LOCK && a[1:0] == 2'h0;
  endfunction

  // ************************************************
  // state
  // ************************************************
  cfg_t cfg, next_cfg;
  logic lock, next_lock;
  logic [15:0] flag, next_flag;
  logic [18:0] in_q, in_prev, next_in_q;
  logic [18:0] en_q, en_prev;
  logic [15:0] ev;
  pad_t next_pads;
  logic next_irq, next_wake;
  logic aw_have, w_have, next_aw_have, next_w_have;
  logic [AW-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic do_write;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    // channels taken in either order, held until both are present
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    wr_addr = next_aw_addr;
    wr_data = next_w_data;
    wr_strb = next_w_strb;
    do_write = next_aw_have && next_w_have && !bvalid;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_cfg = cfg;
    next_lock = lock;
    next_flag = flag;
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      // stored even while locked; pads pick them up on release
      case (wr_addr)
        A_OUT: next_cfg.out = 19'(merge(32'(cfg.out), wr_data, wr_strb, PIN_MASK));
        A_DIR: next_cfg.dir = 19'(merge(32'(cfg.dir), wr_data, wr_strb, PIN_MASK));
        A_PEN: next_cfg.pen = 19'(merge(32'(cfg.pen), wr_data, wr_strb, PIN_MASK));
        A_PSEL: next_cfg.psel = 19'(merge(32'(cfg.psel), wr_data, wr_strb, PIN_MASK));
        A_EDGE: next_cfg.edge_sel = 16'(merge(32'(cfg.edge_sel), wr_data, wr_strb, IRQ_MASK));
        A_IE: next_cfg.ie = 16'(merge(32'(cfg.ie), wr_data, wr_strb, IRQ_MASK));
        A_CLR: next_flag = flag & ~16'(merge(32'h0, wr_data, wr_strb, IRQ_MASK));
        A_LOCK: begin
          // only reset sets the lock; software may only release it
          if (wr_strb[0] && !wr_data[LOCK_BIT]) begin
            next_lock = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // a new edge wins over a clear in the same cycle
    next_flag = next_flag | ev;
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;

    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        A_IN: next_rdata = 32'(in_q);
        A_OUT: next_rdata = 32'(cfg.out);
        A_DIR: next_rdata = 32'(cfg.dir);
        A_PEN: next_rdata = 32'(cfg.pen);
        A_PSEL: next_rdata = 32'(cfg.psel);
        A_EDGE: next_rdata = 32'(cfg.edge_sel);
        A_IE: next_rdata = 32'(cfg.ie);
        A_STAT: next_rdata = 32'(flag);
        A_LOCK: next_rdata = 32'(lock);
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // ************************************************
  // pins and events
  // ************************************************
  always_comb begin
    // edges only on groups one and two, never while locked
    // both samples taken with the trigger on, so switching it on is no edge
    for (int i = 0; i < NIRQ; i++) begin
      ev[i] = !lock && en_q[i] && en_prev[i] &&
              (cfg.edge_sel[i] ? (in_prev[i] && !in_q[i]) : (!in_prev[i] && in_q[i]));
    end
    // trigger off reads as zero, so no input toggles while locked
    next_in_q = pin_in & pads.in_en;
    // all pads idle while locked: no drive, no pulls, no trigger
    next_pads = '0;
    if (!next_lock) begin
      next_pads.out = next_cfg.out;
      next_pads.oe = next_cfg.dir;
      next_pads.pull_en = next_cfg.pen & ~next_cfg.dir;
      next_pads.pull_up = next_cfg.psel & next_cfg.pen & ~next_cfg.dir;
      // trigger on for outputs too: they read back and may interrupt
      next_pads.in_en = '1;
    end
    next_irq = |(next_flag & next_cfg.ie);
    next_wake = deep_sleep && next_irq;
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '{RST_PINS, RST_PINS, RST_PINS, RST_PINS, RST_IRQ, RST_IRQ};
      lock <= RST_LOCK;
      flag <= RST_IRQ;
      in_q <= RST_PINS;
      in_prev <= RST_PINS;
      en_q <= RST_PINS;
      en_prev <= RST_PINS;
      pads <= '0;
      irq <= 1'b0;
      wake_req <= 1'b0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      cfg <= next_cfg;
      lock <= next_lock;
      flag <= next_flag;
      in_q <= next_in_q;
      in_prev <= in_q;
      en_q <= pads.in_en;
      en_prev <= en_q;
      pads <= next_pads;
      irq <= next_irq;
      wake_req <= next_wake;
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  property p_lock_hiz;
    @(posedge aclk) disable iff (!aresetn)
    lock |-> (pads.oe == '0 && pads.in_en == '0 && pads.pull_en == '0);
  endproperty
  a_lock_hiz: assert property (p_lock_hiz) else $error("pads active while locked");

  property p_lock_stays;
    @(posedge aclk) disable iff (!aresetn)
    !lock |=> !lock;
  endproperty
  a_lock_stays: assert property (p_lock_stays) else $error("lock set again");

  property p_apply;
    @(posedge aclk) disable iff (!aresetn)
    !lock |-> (pads.oe == cfg.dir && pads.out == cfg.out);
  endproperty
  a_apply: assert property (p_apply) else $error("pads differ from config");

  property p_pull;
    @(posedge aclk) disable iff (!aresetn)
    !lock |-> (pads.pull_en == (cfg.pen & ~cfg.dir)) && ((pads.pull_up & ~pads.pull_en) == '0);
  endproperty
  a_pull: assert property (p_pull) else $error("pull setting wrong");

  property p_rise;
    @(posedge aclk) disable iff (!aresetn)
    (en_q[0] && en_prev[0] && in_q[0] && !in_prev[0] && !cfg.edge_sel[0]) |=> flag[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge lost");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    irq == |(flag & cfg.ie);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not from enabled flags");

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
    ($past(deep_sleep) && irq) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in deep sleep");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid ##0 (!awready && !wready);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write not answered");

  property p_byte;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_addr == A_OUT && wr_strb == 4'h1) |=>
      (cfg.out[18:8] == $past(cfg.out[18:8]) && cfg.out[7:0] == $past(wr_data[7:0]));
  endproperty
  a_byte: assert property (p_byte) else $error("byte write disturbed other lanes");
endmodule

/* File: bench/pin_board.sv */
// board model: resolves each pin from the pads, the pulls and the bench
`timescale 1ns/10ps
module pin_board
  import gpio_pkg::*;
(
  // pads and outside stimulus
  input wire pad_t pads,
  input wire logic [18:0] board,
  // pin levels
  output logic [18:0] pin_in
);
  // own drive wins, a pull wins over the bench line, driven or not
  always_comb begin
    for (int i = 0; i < 19; i++) begin
      if (pads.oe[i]) pin_in[i] = pads.out[i];
      else if (pads.pull_en[i]) pin_in[i] = pads.pull_up[i];
      else pin_in[i] = board[i];
    end
  end
endmodule

/* File: bench/gpio_ports_tb.sv */
// testbench for the gpio ports block
`timescale 1ns/10ps
module gpio_ports_tb;
  import gpio_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irq, wake_req, deep_sleep = 0;
  logic [18:0] pin_in, board = 19'h00000;
  pad_t pads;
  int failures = 0, check_count = 0, cyc = 0;
  gpio_ports i_gpio_ports (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pin_in(pin_in), .pads(pads), .deep_sleep(deep_sleep), .irq(irq),
    .wake_req(wake_req));
  pin_board i_pin_board (.pads(pads), .board(board), .pin_in(pin_in));
  always #5 aclk = ~aclk;
  // ************************************************
  // bus tasks and checks
  // ************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge aclk);
      ah = awready; wh = wready; bh = bvalid; resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
    end while (!bh);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge aclk);
      ah = arready; rh = rvalid; resp = rresp; rd_val = rdata;
      @(posedge aclk);
      if (ah) arvalid <= 0;
    end while (!rh);
    rready <= 0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge aclk);
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset();
    board <= 19'h7FFFF;
    settle();
    chk("oe", 0, 32'(pads.oe));
    chk("pull_en", 0, 32'(pads.pull_en));
    chk("in_en", 0, 32'(pads.in_en));
    rd(A_LOCK); chk("lock", 1, rd_val);
    rd(A_IN); chk("in locked", 0, rd_val);
  endtask
  task automatic t_lock();
    wr(A_OUT, 32'h5A3C1, 4'hF); wr(A_DIR, 32'h7FFFF, 4'hF);
    settle(); chk("oe locked", 0, 32'(pads.oe));
    wr(A_LOCK, 0, 4'hF); settle();
    chk("out", 32'h5A3C1, 32'(pads.out));
    chk("oe", 32'h7FFFF, 32'(pads.oe));
    rd(A_IN); chk("in", 32'h5A3C1, rd_val);
    wr(A_LOCK, 1, 4'hF); rd(A_LOCK); chk("relock", 0, rd_val);
    wr(A_OUT, 32'hFFFFFFFF, 4'hF); rd(A_OUT); chk("width", PIN_MASK, rd_val);
  endtask
  task automatic t_pull();
    // board held high, so the low bits prove the pull-down
    board <= 19'h7FFFF;
    wr(A_DIR, 0, 4'hF); wr(A_PEN, 32'h7FFFF, 4'hF); wr(A_PSEL, 32'h2D5A6, 4'hF);
    settle(); rd(A_IN); chk("pull", 32'h2D5A6, rd_val);
    wr(A_PEN, 0, 4'hF);
    board <= 19'h00000;
  endtask
  task automatic t_irq();
    wr(A_EDGE, 32'h00FF, 4'hF); wr(A_IE, 32'hFFFF, 4'hF); wr(A_CLR, 32'hFFFF, 4'hF);
    rd(A_STAT); chk("stat idle", 0, rd_val);
    board <= 19'h7FFFF; settle();
    rd(A_STAT); chk("rise", 32'hFF00, rd_val);
    chk("irq", 1, 32'(irq));
    deep_sleep <= 1; settle(); chk("wake", 1, 32'(wake_req));
    @(posedge aclk);
    board <= 19'h00000; settle();
    rd(A_STAT); chk("fall", 32'hFFFF, rd_val);
    wr(A_IE, 0, 4'hF); settle(); chk("masked", 0, 32'(irq));
    chk("wake off", 0, 32'(wake_req));
    wr(A_CLR, 32'hFFFF, 4'hF); rd(A_STAT); chk("cleared", 0, rd_val);
    rd(A_CLR); chk("clr reads", 0, rd_val);
    deep_sleep <= 0;
  endtask
  task automatic t_bus();
    wr(A_OUT, 0, 4'hF);
    chk("wr ok", 32'(RESP_OKAY), 32'(resp));
    wr(A_OUT, 32'h00AB0000, 4'b0100);
    wr(A_OUT, 32'h1234, 4'b0011); rd(A_OUT); chk("bytes", 32'h31234, rd_val);
    chk("rd ok", 32'(RESP_OKAY), 32'(resp));
    wr(A_OUT, rd_val | 32'h80, 4'hF); rd(A_OUT); chk("rmw", 32'h312B4, rd_val);
    wr(8'h40, 32'h1, 4'hF); chk("wr err", 32'(RESP_SLVERR), 32'(resp));
    rd(8'h40); chk("rd err", 32'(RESP_SLVERR), 32'(resp));
    chk("rd err data", 0, rd_val);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the roughly 140 cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_lock();
    t_pull();
    t_irq();
    t_bus();
    wrap_up();
  end
endmodule
